/* File: rtl/mms_manual_setup.sv */
// manual mode select, axis removal and zero point set logic with apb registers
// Function
// - removal-two bit takes the axis out of the controlled set.
// - removed axis loses position control but keeps position detection running.
// - removed axis sees its interlock as asserted regardless of the bit.
// - zero init mode bit selects marked-point zero setting for that axis.
// - zero init bits never select an operation mode; motion comes from jog/wheel.
// - zero init bits act only with absolute detection and type two.
// - set-start rising after moving in zero init mode captures the zero point.
// - set-start ignored in emergency stop, reset, or before first grid pulse.
// - set-start raised before mode is ignored; must drop and rise again.
// - jog mode bit selects jog operation.
// - in jog, plus or minus select moves the axis at rapid speed when fast feed is on, else manual feedrate.
// - duplicated or missing mode selection flags operation error 0101.
// - wheel mode makes the coded axis follow the handwheel, scaled by multiplier.
// - first wheel axis is a five-bit code plus a valid bit.
// - in step mode each select rising starts one incremental move.
// - step move uses rapid speed when fast feed is on, else manual feedrate.
// - random feed mode needs all other manual modes off, and auto off unless simultaneous is valid.
`default_nettype none
module mms_manual_setup
	import mms_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic estop_in,
	input wire logic nc_reset_in,
	input wire logic [MMS_NUM_SYS-1:0] simul_valid_in,
	input wire logic [MMS_NUM_AXES-1:0] grid_pulse_in,
	input wire logic [MMS_NUM_AXES-1:0] abs_detect_in,
	input wire logic [MMS_NUM_AXES-1:0][1:0] abs_type_in,
	output logic irq_out,
	output logic [MMS_NUM_AXES-1:0] controlled_out,
	output logic [MMS_NUM_AXES-1:0] interlock_out,
	output logic [MMS_NUM_AXES-1:0] detect_on_out,
	output logic [MMS_NUM_AXES-1:0] zero_capture_out,
	output mms_move_s [MMS_NUM_AXES-1:0] move_out,
	output mms_mode_e [MMS_NUM_SYS-1:0] mode_out
);

	mms_state_s s_q;
	mms_state_s s_d;
	mms_apb_req_s req;

	assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
		paddr: paddr_in, pwdata: pwdata_in};

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic access;
		logic wr_fire;
		logic hit;
		logic [31:0] rd;
		logic [MMS_STAT_W-1:0] w1c;
		logic [MMS_STAT_W-1:0] events;
		logic [MMS_NUM_SYS-1:0] err;
		logic [MMS_NUM_SYS-1:0] fast;
		logic [2:0] cnt;
		logic [MMS_SYS_W-1:0] c;
		logic [MMS_AXIS_W-1:0] a;
		logic [1:0] sys_i;
		logic removed;
		logic ilk;
		logic zen;
		logic zrise;
		logic [1:0] rise;
		access = 1'b0;
		wr_fire = 1'b0;
		hit = 1'b0;
		rd = 32'h0000_0000;
		w1c = '0;
		events = '0;
		err = '0;
		fast = '0;
		cnt = 3'h0;
		c = '0;
		a = '0;
		sys_i = 2'h0;
		removed = 1'b0;
		ilk = 1'b0;
		zen = 1'b0;
		zrise = 1'b0;
		rise = 2'h0;
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.zero_capture = '0;

		// apb decode; one wait state keeps prdata and pready registered
		access = req.psel & req.penable;
		wr_fire = access & s_q.pready & req.pwrite;
		for (int i = 0; i < MMS_NUM_SYS; i++) begin
			if (req.paddr == MMS_SYS_BASE + 8'(4 * i)) begin
				hit = 1'b1;
				rd = 32'(s_q.sys_cfg[i]);
				if (wr_fire) begin
					s_d.sys_cfg[i] = req.pwdata[MMS_SYS_W-1:0];
				end
			end
		end
		for (int i = 0; i < MMS_NUM_AXES; i++) begin
			if (req.paddr == MMS_AXIS_BASE + 8'(4 * i)) begin
				hit = 1'b1;
				rd = 32'(s_q.axis_cfg[i]);
				if (wr_fire) begin
					s_d.axis_cfg[i] = req.pwdata[MMS_AXIS_W-1:0];
				end
			end
		end
		case (req.paddr)
			MMS_STATUS_OFS: begin
				hit = 1'b1;
				rd = 32'(s_q.status);
				if (wr_fire) begin
					w1c = req.pwdata[MMS_STAT_W-1:0];
				end
			end
			MMS_MASK_OFS: begin
				hit = 1'b1;
				rd = 32'(s_q.mask);
				if (wr_fire) begin
					s_d.mask = req.pwdata[MMS_STAT_W-1:0];
				end
			end
			MMS_STATE_OFS: begin
				hit = 1'b1;
				for (int i = 0; i < MMS_NUM_SYS; i++) begin
					rd[4*i +: 3] = s_q.mode[i];
				end
			end
			MMS_ERRC_OFS: begin
				hit = 1'b1;
				for (int i = 0; i < MMS_NUM_SYS; i++) begin
					if (s_q.mode[i] == MMS_ERROR) begin
						rd[15:0] = MMS_ERR_CODE;
						rd[MMS_B_ERRSYS + i] = 1'b1;
					end
				end
			end
			default: begin
			end
		endcase
		if (access & ~s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.pslverr = ~hit;
			s_d.prdata = req.pwrite ? 32'h0000_0000 : rd;
		end

		////////////////////////////////////////////////////////////////////////////////
		// per system decode
		for (int i = 0; i < MMS_NUM_SYS; i++) begin
			c = s_q.sys_cfg[i];
			fast[i] = c[MMS_B_FAST];
			cnt = 3'({2'h0, c[MMS_B_JOG]} + {2'h0, c[MMS_B_WHEEL]} + {2'h0, c[MMS_B_STEP]}
				+ {2'h0, c[MMS_B_RANDOM]} + {2'h0, c[MMS_B_REFRET]});
			err[i] = (cnt > 3'h1) | ((cnt == 3'h0) & ~c[MMS_B_AUTO])
				| (c[MMS_B_AUTO] & (cnt != 3'h0) & ~simul_valid_in[i]);
			// random feed guarded by the same duplicate check
			if (err[i]) begin
				s_d.mode[i] = MMS_ERROR;
			end else if (c[MMS_B_JOG]) begin
				s_d.mode[i] = MMS_JOG;
			end else if (c[MMS_B_WHEEL]) begin
				s_d.mode[i] = MMS_WHEEL;
			end else if (c[MMS_B_STEP]) begin
				s_d.mode[i] = MMS_STEP;
			end else if (c[MMS_B_RANDOM]) begin
				s_d.mode[i] = MMS_RANDOM;
			end else if (c[MMS_B_REFRET]) begin
				s_d.mode[i] = MMS_REFRET;
			end else begin
				s_d.mode[i] = MMS_AUTO;
			end
			events[i] = err[i] & ~s_q.err_prev[i];
		end
		s_d.err_prev = err;

		////////////////////////////////////////////////////////////////////////////////
		for (int i = 0; i < MMS_NUM_AXES; i++) begin
			a = s_q.axis_cfg[i];
			// axes assigned to a missing system fall back to the first one
			sys_i = (32'(a[MMS_B_ASYS +: 2]) < MMS_NUM_SYS) ? a[MMS_B_ASYS +: 2] : 2'h0;
			c = s_q.sys_cfg[sys_i];
			removed = a[MMS_B_RMV2];
			ilk = a[MMS_B_ILK] | removed;
			s_d.controlled[i] = ~removed;
			s_d.interlock[i] = ilk;
			s_d.detect_on[i] = 1'b1;
			rise = {a[MMS_B_MINUS], a[MMS_B_PLUS]} & ~s_q.sel_prev[i];
			s_d.sel_prev[i] = {a[MMS_B_MINUS], a[MMS_B_PLUS]};
			s_d.move[i] = '0;
			if (s_q.mode[sys_i] == MMS_JOG && !ilk) begin
				// jog motion; rapid from fast request
				s_d.move[i].plus = a[MMS_B_PLUS] & ~a[MMS_B_MINUS];
				s_d.move[i].minus = a[MMS_B_MINUS] & ~a[MMS_B_PLUS];
				s_d.move[i].rapid = fast[sys_i];
			end
			if (s_q.mode[sys_i] == MMS_STEP && !ilk) begin
				s_d.move[i].step_plus = rise[0];
				s_d.move[i].step_minus = rise[1];
				s_d.move[i].rapid = fast[sys_i];
			end
			s_d.move[i].wheel = (s_q.mode[sys_i] == MMS_WHEEL) & ~removed
				& c[MMS_B_WVALID] & (c[MMS_B_WCODE +: 5] == 5'(i + 1));
			s_d.move[i].mult = c[MMS_B_MULT +: 3];
			s_d.move[i].rate = c[MMS_B_RATE +: 5];
			if (grid_pulse_in[i]) begin
				s_d.grid_seen[i] = 1'b1;
			end
			// absolute detection of the marked type only
			zen = abs_detect_in[i] & (abs_type_in[i] == MMS_ABS_TYPE_MARKED);
			// edge only; a start held from before the mode is never taken
			zrise = zen & a[MMS_B_ZSTART] & ~s_q.zstart_prev[i];
			s_d.zstart_prev[i] = zen & a[MMS_B_ZSTART];
			// zero capture, no effect on mode
			s_d.zero_capture[i] = zrise & a[MMS_B_ZMODE] & ~estop_in & ~nc_reset_in
				& s_q.grid_seen[i];
			events[MMS_B_ZDONE + i] = s_d.zero_capture[i];
		end

		// set wins over write-one-clear
		s_d.status = (s_q.status & ~w1c) | events;
		s_d.irq = |(s_d.status & s_d.mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
			// reset parks every system in the error state until a mode is chosen
			s_q.mode <= '{default: MMS_ERROR};
			s_q.controlled <= '1;
			s_q.detect_on <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata_out = s_q.prdata;
	assign pready_out = s_q.pready;
	assign pslverr_out = s_q.pslverr;
	assign irq_out = s_q.irq;
	assign controlled_out = s_q.controlled;
	assign interlock_out = s_q.interlock;
	assign detect_on_out = s_q.detect_on;
	assign zero_capture_out = s_q.zero_capture;
	assign move_out = s_q.move;
	assign mode_out = s_q.mode;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);

	removal_uncontrol_a: assert property (
		s_q.axis_cfg[0][MMS_B_RMV2] |=> !controlled_out[0])
		else $error("removed axis still controlled");
	removal_detect_a: assert property (
		s_q.axis_cfg[0][MMS_B_RMV2] |=> detect_on_out[0] && !move_out[0].plus)
		else $error("removed axis lost detection or moves");
	removal_interlock_a: assert property (
		s_q.axis_cfg[0][MMS_B_RMV2] |=> interlock_out[0])
		else $error("removed axis interlock not forced");
	zero_type_a: assert property (
		zero_capture_out[0] |-> $past(abs_type_in[0]) == MMS_ABS_TYPE_MARKED
			&& $past(abs_detect_in[0]))
		else $error("zero capture without marked absolute type");
	zero_blocked_a: assert property (
		zero_capture_out[0] |-> !$past(estop_in) && !$past(nc_reset_in)
			&& $past(s_q.grid_seen[0]))
		else $error("zero capture in stop, reset or before grid");
	zero_edge_a: assert property (
		zero_capture_out[0] |-> !$past(s_q.zstart_prev[0], 1)
			&& $past(s_q.axis_cfg[0][MMS_B_ZMODE]))
		else $error("zero capture without fresh start in mode");
	mode_dup_a: assert property (
		s_q.sys_cfg[0][MMS_B_JOG] && s_q.sys_cfg[0][MMS_B_WHEEL] |=> mode_out[0] == MMS_ERROR)
		else $error("duplicate mode not flagged");
	step_pulse_a: assert property (
		move_out[0].step_plus |=> !move_out[0].step_plus)
		else $error("step start longer than one cycle");
	irq_level_a: assert property (
		(s_q.status & s_q.mask) != '0 |-> irq_out)
		else $error("interrupt low with pending unmasked status");

	zero_gate_a: assert property (
		!s_q.axis_cfg[0][MMS_B_ZMODE] |=> !zero_capture_out[0])
		else $error("zero capture outside zero init mode");
	mode_hold_a: assert property (
		$stable(s_q.sys_cfg[0]) && $stable(simul_valid_in[0]) |=> $stable(mode_out[0]))
		else $error("mode changed without a mode bit change");
	zero_take_a: assert property (
		abs_detect_in[0] && abs_type_in[0] == MMS_ABS_TYPE_MARKED && !estop_in
			&& !nc_reset_in && s_q.grid_seen[0] && s_q.axis_cfg[0][MMS_B_ZMODE]
			&& s_q.axis_cfg[0][MMS_B_ZSTART] && !s_q.zstart_prev[0]
			|=> zero_capture_out[0])
		else $error("valid zero set start not captured");
	zero_status_a: assert property (
		zero_capture_out[0] |-> s_q.status[MMS_B_ZDONE])
		else $error("zero capture not flagged in status");
	jog_source_a: assert property (
		mode_out[0] == MMS_JOG |-> $past(s_q.sys_cfg[0][MMS_B_JOG]))
		else $error("jog mode without jog bit");
	jog_motion_a: assert property (
		mode_out[0] == MMS_JOG && s_q.axis_cfg[0][MMS_B_ASYS +: 2] == '0
			&& !s_q.axis_cfg[0][MMS_B_ILK] && !s_q.axis_cfg[0][MMS_B_RMV2]
			&& s_q.axis_cfg[0][MMS_B_PLUS] && !s_q.axis_cfg[0][MMS_B_MINUS]
			|=> move_out[0].plus)
		else $error("jog plus select did not move the axis");
	jog_rapid_a: assert property (
		mode_out[0] == MMS_JOG && s_q.axis_cfg[0][MMS_B_ASYS +: 2] == '0
			&& !s_q.axis_cfg[0][MMS_B_ILK] && !s_q.axis_cfg[0][MMS_B_RMV2]
			|=> move_out[0].rapid == $past(s_q.sys_cfg[0][MMS_B_FAST]))
		else $error("jog rapid does not follow fast feed request");
	feed_setting_a: assert property (
		s_q.axis_cfg[0][MMS_B_ASYS +: 2] == '0
			|=> move_out[0].rate == $past(s_q.sys_cfg[0][MMS_B_RATE +: 5])
			&& move_out[0].mult == $past(s_q.sys_cfg[0][MMS_B_MULT +: 3]))
		else $error("feedrate or multiplier not passed to the axis");
	wheel_source_a: assert property (
		mode_out[0] == MMS_WHEEL |-> $past(s_q.sys_cfg[0][MMS_B_WHEEL]))
		else $error("wheel mode without wheel bit");
	wheel_valid_a: assert property (
		s_q.axis_cfg[0][MMS_B_ASYS +: 2] == '0 && !s_q.sys_cfg[0][MMS_B_WVALID]
			|=> !move_out[0].wheel)
		else $error("wheel follows without a valid axis code");
	step_source_a: assert property (
		mode_out[0] == MMS_STEP |-> $past(s_q.sys_cfg[0][MMS_B_STEP]))
		else $error("step mode without step bit");
	step_edge_a: assert property (
		move_out[0].step_minus |-> $past(s_q.axis_cfg[0][MMS_B_MINUS])
			&& !$past(s_q.sel_prev[0][1]))
		else $error("step start without a rising select");
	step_rate_a: assert property (
		mode_out[0] == MMS_STEP && s_q.axis_cfg[0][MMS_B_ASYS +: 2] == '0
			&& !s_q.axis_cfg[0][MMS_B_ILK] && !s_q.axis_cfg[0][MMS_B_RMV2]
			|=> move_out[0].rapid == $past(s_q.sys_cfg[0][MMS_B_FAST]))
		else $error("step speed does not follow fast feed request");
	random_source_a: assert property (
		mode_out[0] == MMS_RANDOM |-> $past(s_q.sys_cfg[0][MMS_B_RANDOM])
			&& (!$past(s_q.sys_cfg[0][MMS_B_AUTO]) || $past(simul_valid_in[0])))
		else $error("random feed selected beside auto mode");
	sys_split_a: assert property (
		$stable(s_q.sys_cfg[1]) && $stable(simul_valid_in[1]) |=> $stable(mode_out[1]))
		else $error("second system mode moved by another system");
	removal_motion_a: assert property (
		s_q.axis_cfg[0][MMS_B_RMV2] |=> !move_out[0].minus && !move_out[0].wheel
			&& !move_out[0].step_plus && !move_out[0].step_minus)
		else $error("removed axis still commanded");
	interlock_follow_a: assert property (
		!s_q.axis_cfg[0][MMS_B_RMV2]
			|=> interlock_out[0] == $past(s_q.axis_cfg[0][MMS_B_ILK]))
		else $error("interlock output does not follow its bit");
	pready_pulse_a: assert property (
		pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	irq_low_a: assert property (
		(s_q.status & s_q.mask) == '0 |-> !irq_out)
		else $error("interrupt high without pending unmasked status");

endmodule
`default_nettype wire

/* File: rtl/mms_pkg.sv */
// package: constants, register map and carrier types of the manual mode block
`default_nettype none
package mms_pkg;
	localparam int MMS_NUM_SYS = 3;
	localparam int MMS_NUM_AXES = 3;
	localparam int MMS_SYS_W = 21;
	localparam int MMS_AXIS_W = 8;
	localparam int MMS_STAT_W = 16;

	// register byte offsets
	localparam logic [7:0] MMS_SYS_BASE = 8'h00;
	localparam logic [7:0] MMS_AXIS_BASE = 8'h10;
	localparam logic [7:0] MMS_STATUS_OFS = 8'h20;
	localparam logic [7:0] MMS_MASK_OFS = 8'h24;
	localparam logic [7:0] MMS_STATE_OFS = 8'h28;
	localparam logic [7:0] MMS_ERRC_OFS = 8'h2c;

	// system mode register fields
	localparam int MMS_B_JOG = 0;
	localparam int MMS_B_WHEEL = 1;
	localparam int MMS_B_STEP = 2;
	localparam int MMS_B_RANDOM = 3;
	localparam int MMS_B_REFRET = 4;
	localparam int MMS_B_AUTO = 5;
	localparam int MMS_B_FAST = 6;
	localparam int MMS_B_MULT = 7;
	localparam int MMS_B_WCODE = 10;
	localparam int MMS_B_WVALID = 15;
	localparam int MMS_B_RATE = 16;

	// axis command register fields
	localparam int MMS_B_PLUS = 0;
	localparam int MMS_B_MINUS = 1;
	localparam int MMS_B_RMV2 = 2;
	localparam int MMS_B_ILK = 3;
	localparam int MMS_B_ZMODE = 4;
	localparam int MMS_B_ZSTART = 5;
	localparam int MMS_B_ASYS = 6;

	// status and error code register fields
	localparam int MMS_B_ZDONE = 8;
	localparam int MMS_B_ERRSYS = 16;

	localparam logic [1:0] MMS_ABS_TYPE_MARKED = 2'h2;
	localparam logic [15:0] MMS_ERR_CODE = 16'h0101;

	typedef enum logic [2:0] {
		MMS_NONE,
		MMS_JOG,
		MMS_WHEEL,
		MMS_STEP,
		MMS_RANDOM,
		MMS_REFRET,
		MMS_AUTO,
		MMS_ERROR
	} mms_mode_e;

	typedef struct packed {
		logic plus;
		logic minus;
		logic step_plus;
		logic step_minus;
		logic wheel;
		logic rapid;
		logic [2:0] mult;
		logic [4:0] rate;
	} mms_move_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} mms_apb_req_s;

	typedef struct packed {
		logic [MMS_NUM_SYS-1:0][MMS_SYS_W-1:0] sys_cfg;
		logic [MMS_NUM_AXES-1:0][MMS_AXIS_W-1:0] axis_cfg;
		logic [MMS_STAT_W-1:0] status;
		logic [MMS_STAT_W-1:0] mask;
		logic [MMS_NUM_SYS-1:0] err_prev;
		logic [MMS_NUM_AXES-1:0][1:0] sel_prev;
		logic [MMS_NUM_AXES-1:0] zstart_prev;
		logic [MMS_NUM_AXES-1:0] grid_seen;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic [MMS_NUM_AXES-1:0] controlled;
		logic [MMS_NUM_AXES-1:0] interlock;
		logic [MMS_NUM_AXES-1:0] detect_on;
		logic [MMS_NUM_AXES-1:0] zero_capture;
		mms_move_s [MMS_NUM_AXES-1:0] move;
		mms_mode_e [MMS_NUM_SYS-1:0] mode;
	} mms_state_s;
endpackage
`default_nettype wire

/* File: test/mms_plc_model.sv */
// apb master model standing in for the sequence program
`default_nettype none
module mms_plc_model
	import mms_pkg::*;
(
	input wire logic clock_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// request held until pready seen; only the bench watchdog ends a hung wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clock_in);
		penable_out <= 1'b1;
		do begin
			@(posedge clock_in);
		end while (pready_in !== 1'b1);
		q = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		pwdata_out <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench of the manual mode block
`default_nettype none
module tb_top;
	import mms_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, reset_n_in, estop, ncr, irq, psel, pen, pwr, rdy, err, err_seen;
	logic [7:0] pa;
	logic [31:0] pwd, prd, q;
	logic [2:0] simul, grid, absd, ctl, ilk, det, zc;
	logic [2:0][1:0] abst;
	mms_move_s [2:0] mv;
	mms_mode_e [2:0] md;
	mms_mode_e em[4] = '{MMS_JOG, MMS_WHEEL, MMS_STEP, MMS_RANDOM};
	int error_cnt = 0;
	int total_checks = 0;
	mms_manual_setup dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(rdy), .pslverr_out(err), .estop_in(estop), .nc_reset_in(ncr),
		.simul_valid_in(simul), .grid_pulse_in(grid), .abs_detect_in(absd),
		.abs_type_in(abst), .irq_out(irq), .controlled_out(ctl), .interlock_out(ilk),
		.detect_on_out(det), .zero_capture_out(zc), .move_out(mv), .mode_out(md));
	mms_plc_model plc (.clock_in(clock_in), .psel_out(psel), .penable_out(pen),
		.pwrite_out(pwr), .paddr_out(pa), .pwdata_out(pwd), .prdata_in(prd),
		.pready_in(rdy), .pslverr_in(err));
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic re;
		plc.xfer(1'b1, a, d, rq, re);
	endtask
	task automatic r(input logic [7:0] a);
		plc.xfer(1'b0, a, 32'h0, q, err_seen);
	endtask
	task automatic zs(input logic [31:0] d, input logic x);
		w(MMS_AXIS_BASE, d);
		tk(1);
		chk(zc[0], x);
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog: whole run is a few hundred cycles
	initial begin
		#200000;
		error_cnt++;
		summarize;
	end
	initial begin
		{reset_n_in, estop, ncr, simul, grid} = '0;
		absd = 3'h7;
		abst = {3{2'h2}};
		tk(7);
		chk(det, 3'h7);
		chk(md[0], MMS_ERROR);
		@(posedge clock_in);
		reset_n_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			w(MMS_SYS_BASE, 32'h1 << i);
			tk(1);
			chk(md[0], em[i]);
			chk(md[1], MMS_ERROR);
		end
		w(MMS_SYS_BASE, 32'h28);
		tk(1);
		chk(md[0], MMS_ERROR);
		w(MMS_SYS_BASE, 32'h3);
		tk(1);
		chk(md[0], MMS_ERROR);
		r(MMS_ERRC_OFS);
		chk(q[15:0], MMS_ERR_CODE);
		r(MMS_STATUS_OFS);
		chk(q[0], 1'b1);
		// jog with fast feed request set together with the mode bit
		w(MMS_SYS_BASE, 32'h000a0041);
		w(MMS_AXIS_BASE, 32'h1);
		tk(2);
		chk({mv[0].plus, mv[0].rapid, mv[0].rate}, 7'h6a);
		w(MMS_AXIS_BASE, 32'h2);
		tk(1);
		chk({mv[0].plus, mv[0].minus}, 2'h1);
		for (int c = 1; c < 4; c++) begin
			w(MMS_SYS_BASE, 32'h8182 | (c << 10));
			tk(2);
			chk({mv[c-1].wheel, mv[c-1].mult}, 4'hb);
		end
		w(MMS_SYS_BASE, 32'h0582);
		tk(2);
		chk(mv[0].wheel, 1'b0);
		w(MMS_AXIS_BASE, 32'h0);
		w(MMS_SYS_BASE, 32'h104);
		tk(2);
		w(MMS_AXIS_BASE, 32'h1);
		tk(1);
		chk({mv[0].step_plus, mv[0].rapid, mv[0].mult}, 5'h12);
		tk(1);
		chk(mv[0].step_plus, 1'b0);
		w(MMS_SYS_BASE, 32'h144);
		tk(2);
		w(MMS_AXIS_BASE, 32'h2);
		tk(1);
		chk({mv[0].step_minus, mv[0].rapid}, 2'h3);
		w(MMS_AXIS_BASE + 8'h04, 32'h4);
		tk(1);
		chk({ctl, ilk, det}, 9'h157);
		w(MMS_AXIS_BASE + 8'h04, 32'h0);
		tk(1);
		chk(ilk[1], 1'b0);
		zs(32'h10, 1'b0);
		zs(32'h30, 1'b0);
		zs(32'h10, 1'b0);
		@(posedge clock_in);
		grid <= 3'h1;
		@(posedge clock_in);
		grid <= 3'h0;
		zs(32'h30, 1'b1);
		r(MMS_STATUS_OFS);
		chk({q[8], irq}, 2'h2);
		w(MMS_MASK_OFS, 32'h100);
		tk(1);
		chk(irq, 1'b1);
		w(MMS_STATUS_OFS, 32'h100);
		tk(1);
		chk(irq, 1'b0);
		zs(32'h0, 1'b0);
		zs(32'h20, 1'b0);
		zs(32'h30, 1'b0);
		zs(32'h10, 1'b0);
		zs(32'h30, 1'b1);
		for (int k = 0; k < 5; k++) begin
			zs(32'h10, 1'b0);
			@(posedge clock_in);
			estop <= (k == 0);
			ncr <= (k == 1);
			abst[0] <= (k == 2) ? 2'h1 : 2'h2;
			absd[0] <= (k != 3);
			if (k < 4) zs(32'h30, 1'b0);
		end
		chk(md[0], MMS_STEP);
		r(8'h30);
		chk(q, 32'h0000_0000);
		chk(err_seen, 1'b1);
		summarize;
	end
endmodule
`default_nettype wire
